// ===== phy_mii_mgmt_registers.sv
// PHY management register bank behind a serial management slave
`timescale 1ns/100ps
module phy_mii_mgmt_registers #(
    parameter logic [4:0] PHY_ADDR = 5'h01,
    // Identity values are arbitrary
    parameter logic [15:0] IDENT_HIGH = 16'h0a5a,
    parameter logic [15:0] IDENT_LOW = 16'h5a00
) (
    // Clock, reset, enable
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // Serial management pins
    input wire logic mdc_in,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_out,
    // Transceiver core
    input mii_mgmt_pkg::phy_stat_t stat_in,
    output mii_mgmt_pkg::phy_ctrl_t ctrl_out
);

    // ************************************************************
    // State
    // ************************************************************
    mii_mgmt_pkg::mgmt_state_t s_r;
    mii_mgmt_pkg::mgmt_state_t s_nxt;
    logic rise;
    logic bit_in;
    logic wr_en;
    logic st_rd;
    logic [15:0] wdata;
    logic [12:0] head;
    logic [15:0] stat_word;

    function automatic logic [15:0] rd_word(
        input mii_mgmt_pkg::mgmt_state_t s,
        input mii_mgmt_pkg::phy_stat_t st, input logic [15:0] sw);
        logic [15:0] v;
        v = 16'h0000;
        case (s.reg_addr)
            mii_mgmt_pkg::ADDR_CTRL:
            begin
                v = s.ctrl;
                v[mii_mgmt_pkg::CTRL_RESET] = s.reset_busy;
                v[mii_mgmt_pkg::CTRL_RESTART] = s.restart_pend;
            end
            mii_mgmt_pkg::ADDR_STAT: v = sw;
            mii_mgmt_pkg::ADDR_ID_HI: v = IDENT_HIGH;
            mii_mgmt_pkg::ADDR_ID_LO: v = IDENT_LOW;
            mii_mgmt_pkg::ADDR_ADV: v = s.adv;
            mii_mgmt_pkg::ADDR_PARTNER: v = st.partner_ability;
            mii_mgmt_pkg::ADDR_EXPAN: v = st.expansion;
            mii_mgmt_pkg::ADDR_NPTX: v = s.nptx;
            mii_mgmt_pkg::ADDR_NPRX: v = st.np_receive;
            mii_mgmt_pkg::ADDR_GCTL: v = s.gctl;
            mii_mgmt_pkg::ADDR_GSTAT: v = st.gig_status;
            mii_mgmt_pkg::ADDR_GEXT: v = mii_mgmt_pkg::GEXT_VAL;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        s_nxt = s_r;
        wr_en = 1'b0;
        st_rd = 1'b0;
        wdata = 16'h0000;
        // Fixed capability bits; too
        stat_word = mii_mgmt_pkg::STAT_FIXED;
        stat_word[mii_mgmt_pkg::STAT_AN_DONE] = stat_in.an_complete;
        stat_word[mii_mgmt_pkg::STAT_RFAULT] = s_r.rfault;
        stat_word[mii_mgmt_pkg::STAT_LINK] = s_r.link_lat;
        stat_word[mii_mgmt_pkg::STAT_JABBER] = s_r.jabber;

        // Pins are asynchronous: filter until two stages agree
        s_nxt.mdc_sync = {s_r.mdc_sync[1:0], mdc_in};
        s_nxt.mdio_sync = {s_r.mdio_sync[1:0], mdio_in};
        if (s_r.mdc_sync[2] == s_r.mdc_sync[1])
            s_nxt.mdc_q = s_r.mdc_sync[2];
        if (s_r.mdio_sync[2] == s_r.mdio_sync[1])
            s_nxt.mdio_q = s_r.mdio_sync[2];
        rise = s_nxt.mdc_q & ~s_r.mdc_q;
        bit_in = s_nxt.mdio_q;
        head = {s_r.shift[11:0], bit_in};
        // ********************************************************
        // Frame machine, one step per management clock rise
        // ********************************************************
        if (rise)
        begin
            case (s_r.state)
                mii_mgmt_pkg::ST_IDLE:
                begin
                    if (bit_in)
                    begin
                        if (s_r.ones != mii_mgmt_pkg::PREAMBLE_LEN)
                            s_nxt.ones = s_r.ones + 6'h01;
                    end
                    else
                    begin
                        // Full preamble needed only while not yet synced
                        if (s_r.pre_ok ||
                            s_r.ones == mii_mgmt_pkg::PREAMBLE_LEN)
                        begin
                            s_nxt.pre_ok = 1'b1;
                            s_nxt.state = mii_mgmt_pkg::ST_HEAD;
                            s_nxt.bit_cnt = 5'h00;
                        end
                        s_nxt.ones = 6'h00;
                    end
                end
                mii_mgmt_pkg::ST_HEAD:
                begin
                    s_nxt.shift = {s_r.shift[14:0], bit_in};
                    s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
                    if (s_r.bit_cnt == mii_mgmt_pkg::HEAD_LAST)
                    begin
                        s_nxt.bit_cnt = 5'h00;
                        s_nxt.reg_addr = head[4:0];
                        s_nxt.hit = (head[9:5] == PHY_ADDR);
                        s_nxt.is_read = (head[11:10] == mii_mgmt_pkg::OP_READ);
                        s_nxt.state = mii_mgmt_pkg::ST_TURN;
                        if (!head[12] ||
                            (head[11:10] != mii_mgmt_pkg::OP_READ &&
                             head[11:10] != mii_mgmt_pkg::OP_WRITE))
                        begin
                            s_nxt.pre_ok = 1'b0;
                            s_nxt.state = mii_mgmt_pkg::ST_IDLE;
                        end
                    end
                end
                mii_mgmt_pkg::ST_TURN:
                begin
                    s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
                    if (s_r.bit_cnt == 5'h00)
                    begin
                        if (s_r.is_read && s_r.hit)
                        begin
                            s_nxt.mdio_oe = 1'b1;
                            s_nxt.mdio_o = 1'b0;
                            s_nxt.shift = rd_word(s_r, stat_in, stat_word);
                            st_rd = (s_r.reg_addr == mii_mgmt_pkg::ADDR_STAT);
                        end
                    end
                    else
                    begin
                        s_nxt.bit_cnt = 5'h00;
                        s_nxt.state = mii_mgmt_pkg::ST_DATA;
                        if (s_r.is_read)
                        begin
                            s_nxt.mdio_o = s_r.shift[15];
                            s_nxt.shift = {s_r.shift[14:0], 1'b0};
                        end
                        else if (bit_in)
                        begin
                            // Bad turnaround forces a new preamble
                            s_nxt.pre_ok = 1'b0;
                            s_nxt.state = mii_mgmt_pkg::ST_IDLE;
                        end
                    end
                end
                mii_mgmt_pkg::ST_DATA:
                begin
                    s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
                    if (s_r.is_read)
                    begin
                        s_nxt.mdio_o = s_r.shift[15];
                        s_nxt.shift = {s_r.shift[14:0], 1'b0};
                    end
                    else
                        s_nxt.shift = {s_r.shift[14:0], bit_in};
                    if (s_r.bit_cnt == mii_mgmt_pkg::DATA_LAST)
                    begin
                        s_nxt.state = mii_mgmt_pkg::ST_IDLE;
                        s_nxt.mdio_oe = 1'b0;
                        s_nxt.mdio_o = 1'b0;
                        s_nxt.ones = 6'h00;
                        wdata = {s_r.shift[14:0], bit_in};
                        wr_en = s_r.hit & ~s_r.is_read;
                    end
                end
                default: s_nxt.state = mii_mgmt_pkg::ST_IDLE;
            endcase
        end
        // ********************************************************
        // Status latches; a new event beats a clearing read
        // ********************************************************
        s_nxt.link_lat = st_rd ? stat_in.link_up :
            (s_r.link_lat & stat_in.link_up);
        s_nxt.rfault = stat_in.remote_fault | (s_r.rfault & ~st_rd);
        s_nxt.jabber = stat_in.jabber | (s_r.jabber & ~st_rd);
        if (stat_in.an_started)
            s_nxt.restart_pend = 1'b0;
        if (s_r.reset_busy && (s_r.ctrl[mii_mgmt_pkg::CTRL_ANE] ?
            stat_in.an_started : stat_in.forced_entered))
            s_nxt.reset_busy = 1'b0;
        // ********************************************************
        // Register writes
        // ********************************************************
        if (wr_en)
        begin
            case (s_r.reg_addr)
                mii_mgmt_pkg::ADDR_CTRL:
                begin
                    if (wdata[mii_mgmt_pkg::CTRL_RESET])
                    begin
                        s_nxt.ctrl = mii_mgmt_pkg::CTRL_RST;
                        s_nxt.adv = mii_mgmt_pkg::ADV_RST;
                        s_nxt.nptx = mii_mgmt_pkg::NPTX_RST;
                        s_nxt.gctl = mii_mgmt_pkg::GCTL_RST;
                        s_nxt.rfault = 1'b0;
                        s_nxt.jabber = 1'b0;
                        s_nxt.link_lat = 1'b0;
                        s_nxt.restart_pend = 1'b0;
                        s_nxt.reset_busy = 1'b1;
                    end
                    else
                    begin
                        s_nxt.ctrl = wdata & mii_mgmt_pkg::CTRL_WMASK;
                        // Zero leaves a pending restart alone
                        if (wdata[mii_mgmt_pkg::CTRL_RESTART] &&
                            wdata[mii_mgmt_pkg::CTRL_ANE])
                            s_nxt.restart_pend = 1'b1;
                    end
                end
                mii_mgmt_pkg::ADDR_ADV: s_nxt.adv = mii_mgmt_pkg::ADV_FIXED |
                    (wdata & mii_mgmt_pkg::ADV_WMASK);
                mii_mgmt_pkg::ADDR_NPTX: s_nxt.nptx = wdata &
                    mii_mgmt_pkg::NPTX_WMASK;
                mii_mgmt_pkg::ADDR_GCTL: s_nxt.gctl = wdata;
                default: s_nxt.gctl = s_r.gctl;
            endcase
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            s_r <= '0;
            s_r.ctrl <= mii_mgmt_pkg::CTRL_RST;
            s_r.adv <= mii_mgmt_pkg::ADV_RST;
            s_r.nptx <= mii_mgmt_pkg::NPTX_RST;
            s_r.gctl <= mii_mgmt_pkg::GCTL_RST;
        end
        else if (clk_en_in)
            s_r <= s_nxt;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign mdio_out = s_r.mdio_o;
    assign mdio_oe_out = s_r.mdio_oe;
    assign ctrl_out.soft_reset = s_r.reset_busy;
    assign ctrl_out.loopback = s_r.ctrl[mii_mgmt_pkg::CTRL_LOOP];
    assign ctrl_out.power_down = s_r.ctrl[mii_mgmt_pkg::CTRL_PWD];
    assign ctrl_out.isolate = s_r.ctrl[mii_mgmt_pkg::CTRL_ISO];
    assign ctrl_out.autoneg_enable = s_r.ctrl[mii_mgmt_pkg::CTRL_ANE];
    assign ctrl_out.autoneg_restart = s_r.restart_pend;
    // Forced fields read as zero while negotiation owns the link
    assign ctrl_out.force_active = ~s_r.ctrl[mii_mgmt_pkg::CTRL_ANE];
    assign ctrl_out.forced_speed = ctrl_out.force_active ?
        {s_r.ctrl[mii_mgmt_pkg::CTRL_SPEED_HI],
         s_r.ctrl[mii_mgmt_pkg::CTRL_SPEED_LO]} : 2'h0;
    assign ctrl_out.forced_duplex = ctrl_out.force_active &
        s_r.ctrl[mii_mgmt_pkg::CTRL_DUPLEX];

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in || !clk_en_in);
    logic wr_ctrl;
    assign wr_ctrl = wr_en && s_r.reg_addr == mii_mgmt_pkg::ADDR_CTRL;
    a_soft_reset_load: assert property (wr_ctrl && wdata[15] |=>
        s_r.reset_busy && s_r.ctrl == mii_mgmt_pkg::CTRL_RST &&
        ctrl_out.soft_reset)
        else $error("soft reset did not restore defaults");
    a_soft_reset_end: assert property (s_r.reset_busy &&
        ctrl_out.autoneg_enable && stat_in.an_started && !wr_en
        |=> !s_r.reset_busy)
        else $error("soft reset did not complete on negotiation start");
    a_loopback_write: assert property (wr_ctrl && !wdata[15]
        |=> ctrl_out.loopback == $past(wdata[14]))
        else $error("loopback control not taken");
    a_forced_speed: assert property (wr_ctrl && !wdata[15] &&
        !wdata[12] |=> ctrl_out.forced_speed == {$past(wdata[6]),
        $past(wdata[13])})
        else $error("forced speed bits wrong");
    a_ane_masks_force: assert property (ctrl_out.autoneg_enable
        |-> !ctrl_out.force_active && ctrl_out.forced_speed == 2'h0 &&
        !ctrl_out.forced_duplex)
        else $error("forced fields leak while negotiating");
    a_power_down: assert property (wr_ctrl && !wdata[15]
        |=> ctrl_out.power_down == $past(wdata[11]))
        else $error("power down control not taken");
    a_isolate_write: assert property (wr_ctrl && !wdata[15]
        |=> ctrl_out.isolate == $past(wdata[10]))
        else $error("isolate control not taken");
    a_restart_ignored: assert property (!s_r.restart_pend &&
        wr_ctrl && !wdata[12] |=> !s_r.restart_pend)
        else $error("restart taken with negotiation disabled");
    a_restart_holds: assert property (s_r.restart_pend &&
        !stat_in.an_started && !(wr_ctrl && wdata[15])
        |=> s_r.restart_pend)
        else $error("pending restart dropped early");
    a_duplex_force: assert property (wr_ctrl && !wdata[15] &&
        !wdata[12] |=> ctrl_out.forced_duplex == $past(wdata[8]))
        else $error("forced duplex wrong");
    a_status_fixed: assert property ((stat_word &
        mii_mgmt_pkg::STAT_FIX_MASK) == mii_mgmt_pkg::STAT_FIXED)
        else $error("fixed status bits wrong");
    a_bad_opcode: assert property (rise &&
        s_r.state == mii_mgmt_pkg::ST_HEAD &&
        s_r.bit_cnt == mii_mgmt_pkg::HEAD_LAST && head[11] == head[10]
        |=> !s_r.pre_ok && s_r.state == mii_mgmt_pkg::ST_IDLE)
        else $error("invalid opcode kept preamble sync");
    a_fault_sticky: assert property (stat_in.remote_fault &&
        !(wr_ctrl && wdata[15]) |=> s_r.rfault [*1] ##1 (s_r.rfault ||
        $past(st_rd) || $past(wr_ctrl && wdata[15])))
        else $error("remote fault not latched");
    a_link_drop: assert property (!stat_in.link_up &&
        !st_rd |=> !s_r.link_lat)
        else $error("link drop not held");
    a_adv_readonly: assert property (wr_en &&
        s_r.reg_addr == mii_mgmt_pkg::ADDR_ADV |=> s_r.adv[14] == 1'b0 &&
        s_r.adv[9] == 1'b0 && s_r.adv[4:0] == 5'h01)
        else $error("read-only advertise bits written");
    c_soft_reset: cover property (wr_ctrl && wdata[15]);
    c_status_read: cover property (st_rd);
    c_restart: cover property (s_r.restart_pend ##1 !s_r.restart_pend);
    c_drive_read: cover property (s_r.mdio_oe [*8]);
endmodule

// ===== mii_mgmt_pkg.sv
// Constants, types and state layout for the PHY management register bank
package mii_mgmt_pkg;

    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_STAT = 5'h01;
    localparam logic [4:0] ADDR_ID_HI = 5'h02;
    localparam logic [4:0] ADDR_ID_LO = 5'h03;
    localparam logic [4:0] ADDR_ADV = 5'h04;
    localparam logic [4:0] ADDR_PARTNER = 5'h05;
    localparam logic [4:0] ADDR_EXPAN = 5'h06;
    localparam logic [4:0] ADDR_NPTX = 5'h07;
    localparam logic [4:0] ADDR_NPRX = 5'h08;
    localparam logic [4:0] ADDR_GCTL = 5'h09;
    localparam logic [4:0] ADDR_GSTAT = 5'h0a;
    localparam logic [4:0] ADDR_GEXT = 5'h0f;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_RESET = 15;
    localparam int CTRL_LOOP = 14;
    localparam int CTRL_SPEED_LO = 13;
    localparam int CTRL_ANE = 12;
    localparam int CTRL_PWD = 11;
    localparam int CTRL_ISO = 10;
    localparam int CTRL_RESTART = 9;
    localparam int CTRL_DUPLEX = 8;
    localparam int CTRL_SPEED_HI = 6;
    localparam int STAT_AN_DONE = 5;
    localparam int STAT_RFAULT = 4;
    localparam int STAT_LINK = 2;
    localparam int STAT_JABBER = 1;

    // ************************************************************
    // Reset values, write masks, fixed bits
    // ************************************************************
    localparam logic [15:0] CTRL_RST = 16'h1140;
    localparam logic [15:0] CTRL_WMASK = 16'h7dc0;
    localparam logic [15:0] ADV_RST = 16'h01e1;
    localparam logic [15:0] ADV_WMASK = 16'hbde0;
    localparam logic [15:0] ADV_FIXED = 16'h0001;
    localparam logic [15:0] NPTX_RST = 16'h2001;
    localparam logic [15:0] NPTX_WMASK = 16'ha7ff;
    localparam logic [15:0] GCTL_RST = 16'h0000;
    localparam logic [15:0] STAT_FIX_MASK = 16'hffc9;
    localparam logic [15:0] STAT_FIXED = 16'h7949;
    localparam logic [15:0] GEXT_VAL = 16'h3000;

    // ************************************************************
    // Serial frame timing in management clock bits, opcodes and frame states
    // ************************************************************
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [4:0] HEAD_LAST = 5'h0c;
    localparam logic [4:0] DATA_LAST = 5'h0f;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_HEAD = 2'h1,
        ST_TURN = 2'h3,
        ST_DATA = 2'h2
    } mdio_state_t;

    typedef struct packed {
        logic soft_reset;
        logic loopback;
        logic power_down;
        logic isolate;
        logic autoneg_enable;
        logic autoneg_restart;
        logic force_active;
        logic [1:0] forced_speed;
        logic forced_duplex;
    } phy_ctrl_t;

    typedef struct packed {
        logic link_up;
        logic jabber;
        logic remote_fault;
        logic an_started;
        logic forced_entered;
        logic an_complete;
        logic [15:0] partner_ability;
        logic [15:0] expansion;
        logic [15:0] np_receive;
        logic [15:0] gig_status;
    } phy_stat_t;

    typedef struct packed {
        mdio_state_t state;
        logic [4:0] bit_cnt;
        logic [15:0] shift;
        logic [5:0] ones;
        logic pre_ok;
        logic is_read;
        logic hit;
        logic [4:0] reg_addr;
        logic mdio_o;
        logic mdio_oe;
        logic [2:0] mdc_sync;
        logic [2:0] mdio_sync;
        logic mdc_q;
        logic mdio_q;
        logic [15:0] ctrl;
        logic [15:0] adv;
        logic [15:0] nptx;
        logic [15:0] gctl;
        logic reset_busy;
        logic restart_pend;
        logic rfault;
        logic jabber;
        logic link_lat;
    } mgmt_state_t;

endpackage

// ===== mgmt_master.sv
// Station management master model that drives serial frames
`timescale 1ns/100ps
module mgmt_master (
    // Clock and resolved data line
    input wire logic clk_in,
    input wire logic line_in,
    // Lines driven toward the device
    output logic mdc_out,
    output logic dat_out,
    output logic oe_out
);
    initial
    begin
        mdc_out = 1'b0;
        dat_out = 1'b0;
        oe_out = 1'b0;
    end
    // **********
    // Bit and frame tasks
    // **********
    // Ten cycles low and ten high keep data well clear of the clock rise
    task automatic cyc(input logic d, input logic oe, output logic q);
        @(negedge clk_in);
        mdc_out = 1'b0;
        dat_out = d;
        oe_out = oe;
        repeat (10) @(negedge clk_in);
        q = line_in;
        mdc_out = 1'b1;
        repeat (9) @(negedge clk_in);
    endtask
    task automatic frame(input logic pre, input logic [1:0] op,
        input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd,
        output logic [15:0] rd);
        logic q;
        logic rdop;
        logic [13:0] hd;
        hd = {2'b01, op, pa, ra};
        rdop = (op == mii_mgmt_pkg::OP_READ);
        if (pre)
            for (int i = 0; i < 32; i++)
                cyc(1'b1, 1'b1, q);
        for (int i = 13; i >= 0; i--)
            cyc(hd[i], 1'b1, q);
        cyc(1'b1, !rdop, q);
        cyc(1'b0, !rdop, q);
        for (int i = 15; i >= 0; i--)
        begin
            cyc(wd[i], !rdop, q);
            rd[i] = q;
        end
        oe_out = 1'b0;
    endtask
endmodule

// ===== phy_mii_mgmt_registers_test.sv
// Self-checking bench for the PHY management register bank
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module phy_mii_mgmt_registers_test;
    localparam logic [15:0] id_hi = 16'h0bcd; // Arbitrary value
    localparam logic [15:0] id_lo = 16'h4321; // Arbitrary value
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic clk_en = 1'b1;
    logic mdc;
    logic mdat;
    logic moe;
    logic line;
    logic mdio_out;
    logic mdio_oe_out;
    logic [15:0] rd;
    logic [15:0] w;
    int bad_count = 0;
    int n_tests = 0;
    mii_mgmt_pkg::phy_stat_t stat = '0;
    mii_mgmt_pkg::phy_ctrl_t ctrl_out;
    // Pull-up holds the line high while nobody drives it
    assign line = mdio_oe_out ? mdio_out : (moe ? mdat : 1'b1);
    phy_mii_mgmt_registers #(.PHY_ADDR(5'h01), .IDENT_HIGH(id_hi),
        .IDENT_LOW(id_lo)) i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .clk_en_in(clk_en), .mdc_in(mdc), .mdio_in(line), .mdio_out(mdio_out),
        .mdio_oe_out(mdio_oe_out), .stat_in(stat), .ctrl_out(ctrl_out));
    mgmt_master i_mst (.clk_in(mclk_in), .line_in(line), .mdc_out(mdc),
        .dat_out(mdat), .oe_out(moe));
    initial
    begin
        forever #2.5 mclk_in = ~mclk_in;
    end
    initial
    begin
        repeat (95000) @(posedge mclk_in);
        bad_count++;
        summarize();
    end
    // **********
    // Helpers
    // **********
    task automatic summarize;
        if (bad_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        i_mst.frame(1'b0, mii_mgmt_pkg::OP_WRITE, 5'h01, ra, wd, rd);
    endtask
    task automatic rchk(input logic [4:0] ra, input logic [15:0] ex);
        i_mst.frame(1'b0, mii_mgmt_pkg::OP_READ, 5'h01, ra, 16'h0000, rd);
        `CHK($sformatf("reg%h", ra), ex, rd)
    endtask
    task automatic started;
        stat.an_started = 1'b1;
        @(negedge mclk_in);
        stat.an_started = 1'b0;
        repeat (2) @(negedge mclk_in);
    endtask
    // Status word from {complete, fault, link, jabber}
    function automatic logic [15:0] sexp(input logic [3:0] v);
        return mii_mgmt_pkg::STAT_FIXED |
            {10'h000, v[3:2], 1'b0, v[1:0], 1'b0};
    endfunction
    function automatic mii_mgmt_pkg::phy_ctrl_t cexp(input logic [15:0] v);
        return {1'b0, v[14], v[11], v[10], 3'h1, v[6], v[13], v[8]};
    endfunction
    initial
    begin
        void'($urandom(6992));
        repeat (5) @(negedge mclk_in);
        rst_n_in = 1'b1;
        i_mst.frame(1'b1, mii_mgmt_pkg::OP_READ, 5'h01, 5'h00, 16'h0000, rd);
        `CHK("ctrl", mii_mgmt_pkg::CTRL_RST, rd)
        rchk(mii_mgmt_pkg::ADDR_STAT, sexp(4'h0));
        rchk(mii_mgmt_pkg::ADDR_ID_HI, id_hi);
        rchk(mii_mgmt_pkg::ADDR_ADV, mii_mgmt_pkg::ADV_RST);
        rchk(mii_mgmt_pkg::ADDR_NPTX, mii_mgmt_pkg::NPTX_RST);
        rchk(mii_mgmt_pkg::ADDR_GEXT, mii_mgmt_pkg::GEXT_VAL);
        rchk(5'h0b, 16'h0000);
        stat.link_up = 1'b1;
        stat.an_complete = 1'b1;
        stat.gig_status = 16'($urandom);
        rchk(mii_mgmt_pkg::ADDR_GSTAT, stat.gig_status);
        rchk(mii_mgmt_pkg::ADDR_STAT, sexp(4'h8));
        stat.link_up = 1'b0;
        stat.remote_fault = 1'b1;
        stat.jabber = 1'b1;
        @(negedge mclk_in);
        stat = '{link_up: 1'b1, an_complete: 1'b1, default: '0};
        rchk(mii_mgmt_pkg::ADDR_STAT, sexp(4'hd));
        rchk(mii_mgmt_pkg::ADDR_STAT, sexp(4'ha));
        clk_en = 1'b0;
        stat.remote_fault = 1'b1;
        repeat (4) @(negedge mclk_in);
        stat.remote_fault = 1'b0;
        clk_en = 1'b1;
        rchk(mii_mgmt_pkg::ADDR_STAT, sexp(4'ha));
        for (int i = 0; i < 4; i++)
        begin
            w = 16'($urandom) & 16'h6fff;
            w[6] = i[1];
            w[13] = i[0];
            wr(mii_mgmt_pkg::ADDR_CTRL, w);
            rchk(5'h00, w & mii_mgmt_pkg::CTRL_WMASK);
            `CHK("ctrl_out", cexp(w), ctrl_out)
        end
        wr(5'h00, 16'h1200);
        wr(5'h00, 16'h1000);
        rchk(5'h00, 16'h1200);
        `CHK("restart_pend", 1'b1, ctrl_out.autoneg_restart)
        started();
        `CHK("restart", 1'b0, ctrl_out.autoneg_restart)
        wr(mii_mgmt_pkg::ADDR_ADV, 16'($urandom));
        wr(5'h00, 16'h8000);
        rchk(5'h00, 16'h9140);
        rchk(mii_mgmt_pkg::ADDR_ADV, mii_mgmt_pkg::ADV_RST);
        `CHK("soft_busy", 1'b1, ctrl_out.soft_reset)
        started();
        `CHK("soft_reset", 1'b0, ctrl_out.soft_reset)
        // Bad opcode drops sync, so a bare frame after it is ignored
        i_mst.frame(1'b0, 2'b11, 5'h01, 5'h00, 16'h0000, rd);
        wr(5'h00, 16'h0100);
        i_mst.frame(1'b1, mii_mgmt_pkg::OP_READ, 5'h01, 5'h00, 16'h0000, rd);
        `CHK("resync", mii_mgmt_pkg::CTRL_RST, rd)
        i_mst.frame(1'b0, mii_mgmt_pkg::OP_READ, 5'h02, 5'h00, 16'h0000, rd);
        `CHK("other_addr", 16'hffff, rd)
        wr(5'h00, 16'h8000);
        wr(5'h00, 16'h0100);
        started();
        `CHK("an_ignored", 1'b1, ctrl_out.soft_reset)
        stat.forced_entered = 1'b1;
        @(negedge mclk_in);
        stat.forced_entered = 1'b0;
        `CHK("forced_done", 1'b0, ctrl_out.soft_reset)
        summarize();
    end
endmodule
